// File: sps_regs.svh
// Purpose: Register map, field positions, reset values and clock ratios of the serial port
// Assumes: Register offsets are word indices; the byte address is four times the index
// Notes:   Definitions only
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define SPS_IDX_BUF   8'h13
`define SPS_IDX_CTRL  8'h14
`define SPS_IDX_STAT  8'h94
`define SPS_IDX_ISTS  8'h15
`define SPS_IDX_IMSK  8'h16

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SPS_CTRL_EN   5
`define SPS_CTRL_CKP  4
`define SPS_STAT_SMP  7
`define SPS_STAT_CKE  6
`define SPS_IRQ_DONE  0
`define SPS_IRQ_OVF   1
`define SPS_IRQ_COL   2
`define SPS_CTRL_RST  8'h00
`define SPS_STAT_RST  2'h0
`define SPS_IRQ_RST   3'h0

// ----------------------------------------------------------------------
// Serial clock period in pclk cycles per master rate, and half periods per word
// ----------------------------------------------------------------------
`define SPS_DIV_F4    8'h04
`define SPS_DIV_F16   8'h10
`define SPS_DIV_F64   8'h40
`define SPS_DIV_TMR   8'h80
`define SPS_BITS      5'h10

`endif

// File: sps_pkg.sv
// Purpose: Types shared by the serial port design
// Assumes: Nothing beyond SystemVerilog
// Notes:   Mode codes follow the low nibble of the control register
package sps_pkg;
    typedef enum logic [3:0] {
        SPS_M_F4    = 4'b0000,
        SPS_M_F16   = 4'b0001,
        SPS_M_F64   = 4'b0010,
        SPS_M_TMR   = 4'b0011,
        SPS_S_SSEN  = 4'b0100,
        SPS_S_SSDIS = 4'b0101
    } sps_mode_t;
    typedef enum logic {
        SPS_IDLE = 1'b0,
        SPS_XFER = 1'b1
    } sps_state_t;
endpackage : sps_pkg

// File: sps_spi.sv
// Purpose: Synchronous serial port in SPI mode with an APB register slave
// Assumes: Pins are sampled on pclk (40 MHz); link clock far slower than pclk
// Notes:   No wait states on any APB access
`include "sps_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sps_spi
    import sps_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sdi_i,
    input  wire logic        sck_i,
    input  wire logic        ss_n_i,
    output logic             sck_o,
    output logic             sck_oe,
    output logic             sdo_o,
    output logic             sdo_oe,
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers: ss_n, sck, sdi
    // ------------------------------------------------------------------
    logic [2:0] pin_in;
    logic [2:0] sy1_r;
    logic [2:0] sy2_r;
    logic [2:0] sy3_r;
    logic [2:0] filt_r;
    logic       sck_d_r;
    assign pin_in = {ss_n_i, sck_i, sdi_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sy1_r[gi]  <= (gi == 2);
                    sy2_r[gi]  <= (gi == 2);
                    sy3_r[gi]  <= (gi == 2);
                    filt_r[gi] <= (gi == 2);
                end else begin
                    sy1_r[gi] <= pin_in[gi];
                    sy2_r[gi] <= sy1_r[gi];
                    sy3_r[gi] <= sy2_r[gi];
                    // A change counts only once two stages agree
                    if (sy2_r[gi] == sy3_r[gi]) begin
                        filt_r[gi] <= sy3_r[gi];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= filt_r[1];
        end
    end

    // ------------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [1:0] stat_r;
    logic [7:0] rxbuf_r;
    logic       bf_r;
    logic [2:0] ists_r;
    logic [2:0] imsk_r;
    logic [7:0] idx;
    logic       acc;
    logic       wr_buf;
    logic       rd_buf;
    logic       mapped;
    logic [7:0] rd_val;
    assign idx    = paddr[9:2];
    assign acc    = psel & penable & pready;
    assign wr_buf = acc & pwrite & pstrb[0] & (idx == `SPS_IDX_BUF);
    assign rd_buf = acc & ~pwrite & (idx == `SPS_IDX_BUF);
    assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                    (idx == `SPS_IDX_BUF || idx == `SPS_IDX_CTRL || idx == `SPS_IDX_STAT ||
                     idx == `SPS_IDX_ISTS || idx == `SPS_IDX_IMSK);

    logic       en;
    logic       clock_idle_polarity;
    logic       cke;
    logic       input_sample_phase;
    sps_mode_t  mode;
    logic       master;
    logic       ss_used;
    assign en      = ctrl_r[`SPS_CTRL_EN];
    assign clock_idle_polarity     = ctrl_r[`SPS_CTRL_CKP];
    assign mode    = sps_mode_t'(ctrl_r[3:0]);
    assign master  = (ctrl_r[3:2] == 2'h0);
    assign ss_used = (mode == SPS_S_SSEN);
    assign cke     = stat_r[0];
    assign input_sample_phase     = stat_r[1];

    // Two-wire flags have no source in this mode
    logic da_flag;
    logic stop_flag;
    logic start_flag;
    logic rw_flag;
    logic ua_flag;
    assign da_flag    = 1'b0;
    assign stop_flag  = 1'b0;
    assign start_flag = 1'b0;
    assign rw_flag    = 1'b0;
    assign ua_flag    = 1'b0;

    always_comb begin
        case (idx)
            `SPS_IDX_BUF:  rd_val = rxbuf_r;
            `SPS_IDX_CTRL: rd_val = {2'h0, ctrl_r[5:0]};
            `SPS_IDX_STAT: rd_val = {input_sample_phase, cke, da_flag, stop_flag, start_flag,
                                     rw_flag, ua_flag, bf_r};
            `SPS_IDX_ISTS: rd_val = {5'h00, ists_r};
            `SPS_IDX_IMSK: rd_val = {5'h00, imsk_r};
            default:       rd_val = 8'h00;
        endcase
    end

    // Data is captured in the setup cycle, so it is ready from a flip-flop
    assign pready = psel & penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata  <= (mapped && !pwrite) ? {24'h000000, rd_val} : 32'h0000_0000;
            pslverr <= ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SPS_CTRL_RST;
            stat_r <= `SPS_STAT_RST;
            imsk_r <= `SPS_IRQ_RST;
        end else if (acc & pwrite & pstrb[0] & mapped) begin
            if (idx == `SPS_IDX_CTRL) begin
                ctrl_r <= {2'h0, pwdata[5:0]};
            end
            if (idx == `SPS_IDX_STAT) begin
                stat_r <= pwdata[7:6];
            end
            if (idx == `SPS_IDX_IMSK) begin
                imsk_r <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------
    sps_state_t state_r;
    logic [7:0] tsh_r;
    logic [7:0] rsh_r;
    logic [3:0] bcnt_r;
    logic [7:0] div_r;
    logic [4:0] hidx_r;
    logic       sck_out_r;
    logic       sdo_r;
    logic [7:0] half;

    always_comb begin
        case (mode)
            SPS_M_F4:  half = `SPS_DIV_F4 >> 1;
            SPS_M_F16: half = `SPS_DIV_F16 >> 1;
            SPS_M_F64: half = `SPS_DIV_F64 >> 1;
            default:   half = `SPS_DIV_TMR >> 1;
        endcase
    end

    logic tick;
    logic m_tog;
    logic m_tx;
    logic m_rx;
    logic m_end;
    logic sel;
    logic rise;
    logic fall;
    logic tx_rise;
    logic s_tx;
    logic s_rx;
    logic tx_ev;
    logic rx_ev;
    logic busy;
    logic load;
    logic done;
    logic ld_rx;
    logic [7:0] rx_word;

    assign tick  = master & (state_r == SPS_XFER) & (div_r == half - 8'h01);
    assign m_tog = tick & (hidx_r < `SPS_BITS);
    assign m_tx  = m_tog & (hidx_r[0] == ~cke);
    // Late sampling moves every capture one half period on
    assign m_rx  = tick & (hidx_r[0] == (cke ^ input_sample_phase)) &
                   ((cke & input_sample_phase) ? (hidx_r != 5'h00) : (hidx_r != `SPS_BITS));
    assign m_end = tick & (hidx_r == `SPS_BITS);

    assign sel     = ~ss_used | ~filt_r[2];
    assign rise    = filt_r[1] & ~sck_d_r;
    assign fall    = ~filt_r[1] & sck_d_r;
    assign tx_rise = cke ^ clock_idle_polarity;
    assign s_tx    = en & ~master & sel & ((rise & tx_rise) | (fall & ~tx_rise));
    assign s_rx    = en & ~master & sel & ((rise & ~tx_rise) | (fall & tx_rise));

    assign tx_ev   = master ? m_tx : s_tx;
    assign rx_ev   = master ? m_rx : s_rx;
    assign busy    = master ? (state_r == SPS_XFER) : (bcnt_r != 4'h0);
    assign load    = wr_buf & ~busy;
    assign done    = master ? m_end : (s_rx & (bcnt_r == 4'h7));
    assign rx_word = master ? rsh_r : {rsh_r[6:0], filt_r[0]};
    // A slave word that finds the buffer full, with no buffer read in the same cycle, is dropped as overflow
    assign ld_rx   = done & (master | ~bf_r | rd_buf);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= SPS_IDLE;
            div_r     <= 8'h00;
            hidx_r    <= 5'h00;
            sck_out_r <= 1'b0;
        end else begin
            case (state_r)
                SPS_IDLE: begin
                    sck_out_r <= clock_idle_polarity;
                    div_r     <= 8'h00;
                    hidx_r    <= 5'h00;
                    if (load & en & master) begin
                        state_r <= SPS_XFER;
                    end
                end
                SPS_XFER: begin
                    if (!en || !master) begin
                        state_r <= SPS_IDLE;
                    end else if (tick) begin
                        div_r  <= 8'h00;
                        hidx_r <= hidx_r + 5'h01;
                        if (m_tog) begin
                            sck_out_r <= ~sck_out_r;
                        end
                        if (m_end) begin
                            state_r <= SPS_IDLE;
                        end
                    end else begin
                        div_r <= div_r + 8'h01;
                    end
                end
                default: state_r <= SPS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsh_r <= 8'h00;
            sdo_r <= 1'b0;
        end else if (load) begin
            // With late transmit the first bit must wait for the leading edge
            tsh_r <= cke ? pwdata[7:0] : {pwdata[6:0], 1'b0};
            if (!cke) begin
                sdo_r <= pwdata[7];
            end
        end else if (tx_ev) begin
            sdo_r <= tsh_r[7];
            tsh_r <= {tsh_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsh_r  <= 8'h00;
            bcnt_r <= 4'h0;
        end else begin
            if (rx_ev) begin
                rsh_r <= {rsh_r[6:0], filt_r[0]};
            end
            if (!en || master || !sel) begin
                bcnt_r <= 4'h0;
            end else if (s_rx) begin
                bcnt_r <= (bcnt_r == 4'h7) ? 4'h0 : bcnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxbuf_r <= 8'h00;
            bf_r    <= 1'b0;
        end else if (ld_rx) begin
            rxbuf_r <= rx_word;
            bf_r    <= 1'b1;
        end else if (rd_buf) begin
            bf_r    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, write one to clear; a new event beats the clear
    // ------------------------------------------------------------------
    logic [2:0] ev;
    logic [2:0] clr;
    assign ev  = {wr_buf & busy, done & ~ld_rx, done};
    assign clr = (acc & pwrite & pstrb[0] & (idx == `SPS_IDX_ISTS)) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= `SPS_IRQ_RST;
        end else begin
            ists_r <= (ists_r & ~clr) | ev;
        end
    end
    assign irq_o = |(ists_r & imsk_r);

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    assign sck_o  = sck_out_r;
    assign sck_oe = en & master;
    assign sdo_o  = sdo_r;
    assign sdo_oe = en & (master | sel);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [3:0] rxcnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxcnt_r <= 4'h0;
        end else if (load) begin
            rxcnt_r <= 4'h0;
        end else if (m_rx) begin
            rxcnt_r <= rxcnt_r + 4'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_m_start;
        (load & en & master & state_r == SPS_IDLE) ##1 (state_r == SPS_XFER);
    endsequence
    sequence s_m_idle_clk;
        (sck_oe & sck_o == clock_idle_polarity) [*2];
    endsequence

    a_eight_bits: assert property (m_end |-> (rxcnt_r + {3'h0, m_rx}) == 4'h8)
        else $error("master transfer did not sample eight bits");
    a_slave_clk_in: assert property (!master |-> !sck_oe)
        else $error("slave drives the serial clock");
    a_master_start: assert property (s_m_start |-> s_m_idle_clk)
        else $error("master start did not hold idle clock");
    a_disabled_pins: assert property (!en |-> !sck_oe && !sdo_oe)
        else $error("disabled port drives a pin");
    a_tx_edge: assert property (en && $past(en) && !master && !$past(load) &&
                                $changed(sdo_r) |-> $past(s_tx))
        else $error("data out changed off the transmit edge");
    a_two_wire_zero: assert property (!da_flag && !stop_flag && !start_flag && !rw_flag)
        else $error("two-wire flag set in serial mode");
    a_bf_on_done: assert property (ld_rx |=> bf_r && rxbuf_r == $past(rx_word))
        else $error("received word not moved to buffer");
    a_bf_read_clr: assert property (rd_buf && !done |=> !bf_r)
        else $error("buffer read did not clear full flag");
    a_irq_level: assert property ($rose(ists_r[0]) && imsk_r[0] |-> irq_o)
        else $error("unmasked event did not raise interrupt");
endmodule : sps_spi

`default_nettype wire

// File: sps_peer.sv
// Purpose: Far-side SPI slave peer facing the port in master operation
// Assumes: Idle-low clock, data shifted on falling and taken on rising edge
// Notes:   Behavioural; shows a toggling level once its word is spent
`timescale 1ns/1ps
`default_nettype none

module sps_peer (
    input  wire logic       sck,
    input  wire logic       load,
    input  wire logic       sdo,
    input  wire logic [7:0] reply,
    output logic            sdi,
    output logic [7:0]      rx
);
    int         cnt;
    logic [7:0] sh;

    initial begin
        cnt = 8;
        sdi = 1'b0;
        rx = 8'h00;
        sh = 8'h00;
    end

    always @(posedge load) begin
        sh = reply;
        cnt = 0;
        sdi = reply[7];
    end

    always @(posedge sck) begin
        rx = {rx[6:0], sdo};
    end

    // A released line must not hold its last bit, or stale data could pass
    always @(negedge sck) begin
        cnt++;
        if (cnt < 8) begin
            sdi = sh[7 - cnt];
        end else begin
            sdi = ~sdi;
        end
    end
endmodule : sps_peer

`default_nettype wire

// File: test_sps_spi.sv
// Purpose: Self-checking bench of the serial port in SPI mode
// Assumes: APB with pready from the port; slave clock made here at 200 ns
// Notes:   Register rows first, then transfers, masking and reset
`timescale 1ns/1ps
`default_nettype none

module test_sps_spi;
    import sps_pkg::*;
    typedef struct {
        logic        w;
        logic [7:0]  idx;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } sps_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sdi_tb, sck_tb, ss_n, slv, load, peer_sdi, sdi, e;
    logic        sck_o, sck_oe, sdo_o, sdo_oe, irq_o;
    logic [7:0]  reply, rx, got;
    int          error_cnt, n_tests, n, hf;
    sps_row_t    rows [9];

    // Data-in is only ever driven from outside, data-out only from the port
    assign sdi = slv ? sdi_tb : peer_sdi;

    sps_spi dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sdi_i(sdi),
        .sck_i(sck_tb), .ss_n_i(ss_n), .sck_o(sck_o), .sck_oe(sck_oe),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .irq_o(irq_o));

    sps_peer peer (.sck(sck_o), .load(load), .sdo(sdo_o), .reply(reply),
        .sdi(peer_sdi), .rx(rx));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        n_tests++;
        if (sn !== ex) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk

    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            report_and_stop();
        end
        // A committed write only shows on the outputs after its edge has settled
        @(negedge pclk);
    endtask : apb

    task automatic wait_irq;
        n = 0;
        while (irq_o !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : wait_irq

    initial begin
        {presetn, psel, penable, pwrite, sdi_tb, sck_tb, slv, load} = '0;
        ss_n = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        reply = 8'h00;
        error_cnt = 0;
        n_tests = 0;
        rows = '{'{0, 8'h14, 0, 0, 0}, '{0, 8'h94, 0, 0, 0}, '{1, 8'h14, 32'hff, 0, 0},
            '{0, 8'h14, 0, 32'h3f, 0}, '{1, 8'h14, 0, 0, 0}, '{1, 8'h94, 32'hff, 0, 0},
            '{0, 8'h94, 0, 32'hc0, 0}, '{0, 8'h20, 0, 0, 1}, '{1, 8'h94, 0, 0, 0}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        // ----------------------------------------------------------------
        // Register rows
        // ----------------------------------------------------------------
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].idx, rows[i].wd);
            chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
            if (!rows[i].w) chk("rdata", rows[i].exp, rd);
        end
        // ----------------------------------------------------------------
        // Master transfer at every rate; rate 1 also sees a collision
        // ----------------------------------------------------------------
        apb(1, 8'h16, 32'h1);
        for (int m = 0; m < 4; m++) begin
            reply = 8'ha5 ^ 8'(m);
            apb(1, 8'h14, 32'(m));
            apb(1, 8'h14, 32'h20 | 32'(m));
            chk("sck_oe", 1, {31'h0, sck_oe});
            load <= 1'b1;
            apb(1, 8'h13, 32'h3c + 32'(m));
            load <= 1'b0;
            if (m == 1) apb(1, 8'h13, 32'hff);
            // Half period in pclk cycles of rates /4, /16, /64 and /128
            hf = (m == 3) ? 64 : 2 << (2 * m);
            wait_irq();
            chk("length", 1, {31'h0, n + 3 >= 17 * hf && n <= 17 * hf + 2});
            chk("peer_rx", 32'h3c + 32'(m), {24'h0, rx});
            chk("sck_idle", 0, {31'h0, sck_o});
            apb(0, 8'h94, 0);
            chk("bf_set", 1, rd);
            apb(0, 8'h13, 0);
            if (m != 0) chk("buffer", {24'h0, reply}, rd);
            apb(0, 8'h94, 0);
            chk("bf_clear", 0, rd);
            apb(0, 8'h15, 0);
            chk("int_status", m == 1 ? 5 : 1, rd);
            if (m != 3) apb(1, 8'h15, 32'h7);
        end
        apb(1, 8'h16, 32'h0);
        chk("irq_masked", 0, {31'h0, irq_o});
        apb(1, 8'h16, 32'h1);
        chk("irq_on", 1, {31'h0, irq_o});
        apb(1, 8'h15, 32'h1);
        chk("irq_clear", 0, {31'h0, irq_o});
        apb(1, 8'h14, 32'h0);
        apb(1, 8'h14, 32'h31);
        repeat (2) @(posedge pclk);
        chk("sck_idle_hi", 1, {31'h0, sck_o});
        // ----------------------------------------------------------------
        // Slave word with slave-select, link clock at 200 ns
        // ----------------------------------------------------------------
        apb(1, 8'h14, 32'h0);
        apb(1, 8'h14, 32'h24);
        slv <= 1'b1;
        apb(1, 8'h13, 32'h96);
        chk("sck_oe_slv", 0, {31'h0, sck_oe});
        ss_n <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("sdo_oe_sel", 1, {31'h0, sdo_oe});
        // The port answers a falling edge about five pclk late, so the bit
        // is taken at the end of the high phase rather than on the rise
        for (int b = 7; b >= 0; b--) begin
            sdi_tb <= 1'(8'h5b >> b);
            repeat (4) @(posedge pclk);
            sck_tb <= 1'b1;
            repeat (4) @(posedge pclk);
            got[b] = sdo_o;
            sck_tb <= 1'b0;
        end
        repeat (10) @(posedge pclk);
        chk("slave_tx", 32'h96, {24'h0, got});
        apb(0, 8'h13, 0);
        chk("slave_rx", 32'h5b, rd);
        ss_n <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("sdo_oe_off", 0, {31'h0, sdo_oe});
        // ----------------------------------------------------------------
        // Reset in mid-run
        // ----------------------------------------------------------------
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(0, 8'h14, 0);
        chk("ctrl_rst", 0, rd);
        apb(0, 8'h94, 0);
        chk("stat_rst", 0, rd);
        report_and_stop();
    end
endmodule : test_sps_spi

`default_nettype wire
